// ### hw/tbcfg_pkg.sv
// Shared constants for the touch button configuration register bank
package tbcfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TBCFG_OFS_SLAVE_ADDR  = 8'h01;
  localparam logic [7:0] TBCFG_OFS_FEATURES    = 8'h02;
  localparam logic [7:0] TBCFG_OFS_FLANK_LO    = 8'h04;
  localparam logic [7:0] TBCFG_OFS_FLANK_HI    = 8'h05;
  localparam logic [7:0] TBCFG_OFS_TOGGLE_LO   = 8'h06;
  localparam logic [7:0] TBCFG_OFS_TOGGLE_HI   = 8'h07;
  localparam logic [7:0] TBCFG_OFS_SENS_0_3    = 8'h09;
  localparam logic [7:0] TBCFG_OFS_SENS_4_7    = 8'h0A;
  localparam logic [7:0] TBCFG_OFS_SENS_8_9    = 8'h0B;
  localparam logic [7:0] TBCFG_OFS_DEB_ZERO    = 8'h0E;
  localparam logic [7:0] TBCFG_OFS_DEB_ONE_NINE = 8'h0F;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [6:0] TBCFG_RST_SLAVE_ADDR = 7'h37;
  localparam logic [3:0] TBCFG_RST_FEATURES   = 4'h2;
  localparam logic [7:0] TBCFG_RST_DEBOUNCE   = 8'h01;
  localparam int TBCFG_FEAT_PERIOD_HI = 3;
  localparam int TBCFG_FEAT_PERIOD_LO = 2;
  localparam int TBCFG_FEAT_AUTO_THR  = 1;
  localparam int TBCFG_FEAT_NOISE_HI  = 0;
  localparam int TBCFG_NUM_BUTTONS    = 10;
  localparam int TBCFG_HI_BUTTONS     = 2;

  // Auto-reset period codes and lengths in millisecond ticks
  localparam logic [1:0] TBCFG_PERIOD_5S  = 2'h2;
  localparam logic [1:0] TBCFG_PERIOD_20S = 2'h3;
  localparam logic [14:0] TBCFG_PERIOD_5S_MS  = 15'h1388;
  localparam logic [14:0] TBCFG_PERIOD_20S_MS = 15'h4E20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TBCFG_CLK_PERIOD_NS = 100;
  localparam int TBCFG_TICK_PERIOD_NS = 1000000;
  localparam int TBCFG_TICK_CYCLES = TBCFG_TICK_PERIOD_NS / TBCFG_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    TBCFG_ST_IDLE    = 7'h01,
    TBCFG_ST_ADDR    = 7'h02,
    TBCFG_ST_ACK_ADR = 7'h04,
    TBCFG_ST_WRITE   = 7'h08,
    TBCFG_ST_ACK_WR  = 7'h10,
    TBCFG_ST_READ    = 7'h20,
    TBCFG_ST_ACK_RD  = 7'h40
  } tbcfg_state_t;

  localparam logic [3:0] TBCFG_BITS_PER_BYTE = 4'h8;

endpackage

// ### hw/tbcfg_serial_slave.sv
// Two-wire serial slave that turns bus transfers into register accesses
`timescale 1ns/10ps
`default_nettype none

module tbcfg_serial_slave
  import tbcfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic [6:0] i_slave_addr,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr
);

  tbcfg_state_t state_r;
  logic scl_r;
  logic sda_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic first_r;
  logic nack_r;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  assign start_c = i_scl & scl_r & sda_r & ~i_sda;
  assign stop_c = i_scl & scl_r & ~sda_r & i_sda;
  assign rise_c = i_scl & ~scl_r;
  assign fall_c = ~i_scl & scl_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else
    begin
      scl_r <= i_scl;
      sda_r <= i_sda;
    end
  end

  // Open drain: the pin is only ever pulled low
  always_ff @(posedge i_ref_clk)
  begin
    o_sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      state_r <= TBCFG_ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      o_sda_oe <= 1'b0;
      o_addr <= 8'h00;
      o_wdata <= 8'h00;
      o_wr <= 1'b0;
    end
    else
    begin
      o_wr <= 1'b0;
      if (start_c)
      begin
        state_r <= TBCFG_ST_ADDR;
        cnt_r <= 4'h0;
        o_sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
        state_r <= TBCFG_ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (rise_c)
      begin
        shift_r <= {shift_r[6:0], i_sda};
        cnt_r <= cnt_r + 4'h1;
        if (state_r == TBCFG_ST_ACK_RD)
          nack_r <= i_sda;
      end
      else if (fall_c)
      begin
        case (state_r)
          TBCFG_ST_ADDR:
            if (cnt_r == TBCFG_BITS_PER_BYTE)
            begin
              if (shift_r[7:1] == i_slave_addr)
              begin
                o_sda_oe <= 1'b1;
                rw_r <= shift_r[0];
                state_r <= TBCFG_ST_ACK_ADR;
              end
              else
                state_r <= TBCFG_ST_IDLE;
            end
          TBCFG_ST_ACK_ADR:
          begin
            cnt_r <= 4'h0;
            first_r <= 1'b1;
            if (rw_r)
            begin
              tx_r <= i_rdata;
              o_sda_oe <= ~i_rdata[7];
              state_r <= TBCFG_ST_READ;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              state_r <= TBCFG_ST_WRITE;
            end
          end
          TBCFG_ST_WRITE:
            if (cnt_r == TBCFG_BITS_PER_BYTE)
            begin
              if (first_r)
                o_addr <= shift_r;
              else
              begin
                o_wdata <= shift_r;
                o_wr <= 1'b1;
              end
              o_sda_oe <= 1'b1;
              state_r <= TBCFG_ST_ACK_WR;
            end
          TBCFG_ST_ACK_WR:
          begin
            if (!first_r)
              o_addr <= o_addr + 8'h01;
            first_r <= 1'b0;
            cnt_r <= 4'h0;
            o_sda_oe <= 1'b0;
            state_r <= TBCFG_ST_WRITE;
          end
          TBCFG_ST_READ:
            if (cnt_r == TBCFG_BITS_PER_BYTE)
            begin
              o_sda_oe <= 1'b0;
              o_addr <= o_addr + 8'h01;
              state_r <= TBCFG_ST_ACK_RD;
            end
            else
            begin
              o_sda_oe <= ~tx_r[6];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          TBCFG_ST_ACK_RD:
            if (nack_r)
              state_r <= TBCFG_ST_IDLE;
            else
            begin
              cnt_r <= 4'h0;
              tx_r <= i_rdata;
              o_sda_oe <= ~i_rdata[7];
              state_r <= TBCFG_ST_READ;
            end
          default:
            state_r <= TBCFG_ST_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### hw/tbcfg_regs.sv
// Configuration register bank and per-button touch qualification
`timescale 1ns/10ps
`default_nettype none

module tbcfg_regs
  import tbcfg_pkg::*;
#(
  parameter int P_TICK_CYCLES = TBCFG_TICK_CYCLES,
  parameter int P_BUTTONS = TBCFG_NUM_BUTTONS
)
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_scan_tick,
  input wire logic [P_BUTTONS-1:0] i_touch,
  output logic [P_BUTTONS-1:0] o_button_active,
  output logic [P_BUTTONS-1:0] o_general_output_n,
  output logic [P_BUTTONS-1:0] o_recalibrate,
  output logic [P_BUTTONS-1:0] o_flank_group_member,
  output logic [2*P_BUTTONS-1:0] o_button_sensitivity,
  output logic o_auto_threshold,
  output logic o_noise_immunity_high
);

  logic [6:0] slave_addr_r;
  logic [3:0] features_r;
  logic [7:0] flank_lo_r;
  logic [1:0] flank_hi_r;
  logic [7:0] toggle_lo_r;
  logic [1:0] toggle_hi_r;
  logic [7:0] sens_0_3_r;
  logic [7:0] sens_4_7_r;
  logic [3:0] sens_8_9_r;
  logic [7:0] deb_zero_r;
  logic [7:0] deb_one_nine_r;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic [7:0] rdata;
  logic [31:0] tick_cnt_r;
  logic ms_tick_r;
  logic [1:0] period_code;
  logic period_on;
  logic [14:0] period_ms;
  logic [9:0] toggle_all;

  // ----------------------------------------------------------------
  // Serial access
  // ----------------------------------------------------------------
  tbcfg_serial_slave u_slave (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .i_slave_addr(slave_addr_r),
    .i_rdata(rdata),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .o_wr(bus_wr)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // A new slave address takes effect from the next start condition
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      slave_addr_r <= TBCFG_RST_SLAVE_ADDR;
      features_r <= TBCFG_RST_FEATURES;
      flank_lo_r <= 8'h00;
      flank_hi_r <= 2'h0;
      toggle_lo_r <= 8'h00;
      toggle_hi_r <= 2'h0;
      sens_0_3_r <= 8'h00;
      sens_4_7_r <= 8'h00;
      sens_8_9_r <= 4'h0;
      deb_zero_r <= TBCFG_RST_DEBOUNCE;
      deb_one_nine_r <= TBCFG_RST_DEBOUNCE;
    end
    else if (bus_wr)
    begin
      case (bus_addr)
        TBCFG_OFS_SLAVE_ADDR: slave_addr_r <= bus_wdata[6:0];
        TBCFG_OFS_FEATURES: features_r <= bus_wdata[3:0];
        TBCFG_OFS_FLANK_LO: flank_lo_r <= bus_wdata;
        TBCFG_OFS_FLANK_HI: flank_hi_r <= bus_wdata[1:0];
        TBCFG_OFS_TOGGLE_LO: toggle_lo_r <= bus_wdata;
        TBCFG_OFS_TOGGLE_HI: toggle_hi_r <= bus_wdata[1:0];
        TBCFG_OFS_SENS_0_3: sens_0_3_r <= bus_wdata;
        TBCFG_OFS_SENS_4_7: sens_4_7_r <= bus_wdata;
        TBCFG_OFS_SENS_8_9: sens_8_9_r <= bus_wdata[3:0];
        TBCFG_OFS_DEB_ZERO: deb_zero_r <= bus_wdata;
        TBCFG_OFS_DEB_ONE_NINE: deb_one_nine_r <= bus_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Reserved bits and unmapped offsets read as zero
  always_comb
  begin
    case (bus_addr)
      TBCFG_OFS_SLAVE_ADDR: rdata = {1'b0, slave_addr_r};
      TBCFG_OFS_FEATURES: rdata = {4'h0, features_r};
      TBCFG_OFS_FLANK_LO: rdata = flank_lo_r;
      TBCFG_OFS_FLANK_HI: rdata = {6'h00, flank_hi_r};
      TBCFG_OFS_TOGGLE_LO: rdata = toggle_lo_r;
      TBCFG_OFS_TOGGLE_HI: rdata = {6'h00, toggle_hi_r};
      TBCFG_OFS_SENS_0_3: rdata = sens_0_3_r;
      TBCFG_OFS_SENS_4_7: rdata = sens_4_7_r;
      TBCFG_OFS_SENS_8_9: rdata = {4'h0, sens_8_9_r};
      TBCFG_OFS_DEB_ZERO: rdata = deb_zero_r;
      TBCFG_OFS_DEB_ONE_NINE: rdata = deb_one_nine_r;
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      o_flank_group_member <= '0;
      o_button_sensitivity <= '0;
      o_auto_threshold <= 1'b1;
      o_noise_immunity_high <= 1'b0;
    end
    else
    begin
      o_flank_group_member <= {flank_hi_r, flank_lo_r};
      o_button_sensitivity <= {sens_8_9_r, sens_4_7_r, sens_0_3_r};
      o_auto_threshold <= features_r[TBCFG_FEAT_AUTO_THR];
      o_noise_immunity_high <= features_r[TBCFG_FEAT_NOISE_HI];
    end
  end

  // ----------------------------------------------------------------
  // Millisecond time base for the auto-reset period
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end
    else if (tick_cnt_r == 32'(P_TICK_CYCLES - 1))
    begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  assign period_code =
    features_r[TBCFG_FEAT_PERIOD_HI:TBCFG_FEAT_PERIOD_LO];
  assign period_on = (period_code == TBCFG_PERIOD_5S) ||
                     (period_code == TBCFG_PERIOD_20S);
  assign period_ms = (period_code == TBCFG_PERIOD_5S) ?
                     TBCFG_PERIOD_5S_MS : TBCFG_PERIOD_20S_MS;
  assign toggle_all = {toggle_hi_r, toggle_lo_r};

  // ----------------------------------------------------------------
  // Per-button qualification
  // ----------------------------------------------------------------
  // A button cut off by the auto-reset stays inactive until released,
  // so a stuck object cannot keep the output asserted unless the button's toggle bit is set.
  for (genvar b = 0; b < P_BUTTONS; b++)
  begin : g_btn
    logic [7:0] deb_cnt_r;
    logic [14:0] age_r;
    logic held_r;
    logic act_d_r;
    logic [7:0] deb_lim;

    assign deb_lim = (b == 0) ? deb_zero_r : deb_one_nine_r;

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rstn)
      begin
        deb_cnt_r <= 8'h00;
        age_r <= 15'h0;
        held_r <= 1'b0;
        o_button_active[b] <= 1'b0;
        o_recalibrate[b] <= 1'b0;
      end
      else
      begin
        o_recalibrate[b] <= 1'b0;
        if (i_scan_tick)
        begin
          if (!i_touch[b])
          begin
            deb_cnt_r <= 8'h00;
            held_r <= 1'b0;
            o_button_active[b] <= 1'b0;
          end
          else if (!o_button_active[b] && !held_r)
          begin
            if (deb_cnt_r + 8'h01 >= deb_lim)
              o_button_active[b] <= 1'b1;
            if (deb_cnt_r != 8'hFF)
              deb_cnt_r <= deb_cnt_r + 8'h01;
          end
        end
        if (!o_button_active[b])
          age_r <= 15'h0;
        else if (ms_tick_r && period_on)
        begin
          age_r <= age_r + 15'h1;
          if (age_r + 15'h1 >= period_ms)
          begin
            o_button_active[b] <= 1'b0;
            held_r <= 1'b1;
            o_recalibrate[b] <= 1'b1;
          end
        end
      end
    end

    // Outputs are active low and lag the qualified state by one cycle
    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rstn)
      begin
        act_d_r <= 1'b0;
        o_general_output_n[b] <= 1'b1;
      end
      else
      begin
        act_d_r <= o_button_active[b];
        if (!toggle_all[b])
          o_general_output_n[b] <= ~o_button_active[b];
        else if (o_button_active[b] && !act_d_r)
          o_general_output_n[b] <= ~o_general_output_n[b];
      end
    end
  end

endmodule
`default_nettype wire

// ### sim/tbcfg_host_model.sv
// Two-wire bus host model that performs register transfers
`timescale 1ns/10ps
`default_nettype none

module tbcfg_host_model
(
  input wire logic i_ref_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Reference clocks per bus phase; raise it to make the host slow
  int hc = 3;

  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  task automatic wt();
    repeat (hc) @(posedge i_ref_clk);
    #1;
  endtask

  // Data only moves while the clock is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe = ~b;
    wt();
    o_scl = 1'b1;
    wt();
    r = i_sda;
    o_scl = 1'b0;
    wt();
  endtask

  task automatic start();
    o_sda_oe = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_oe = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask

  task automatic stop();
    o_sda_oe = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_oe = 1'b0;
    wt();
  endtask

  task automatic xfer(input logic [7:0] d, input logic a_in,
                      output logic [7:0] q, output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a_out);
  endtask

  // Mode register is outside this block; configuration mode is assumed
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({a, 1'b0}, 1'b1, q, n0);
    xfer(p, 1'b1, q, n1);
    xfer(d, 1'b1, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] p,
                    output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({a, 1'b0}, 1'b1, q, n0);
    xfer(p, 1'b1, q, n1);
    start();
    xfer({a, 1'b1}, 1'b1, q, n2);
    xfer(8'hFF, 1'b1, d, n3);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule

`default_nettype wire

// ### sim/tbcfg_regs_assertions.sv
// Port assertions for the configuration register bank
`timescale 1ns/10ps
`default_nettype none

module tbcfg_regs_assertions
  import tbcfg_pkg::*;
#(
  parameter int P_TICK_CYCLES = TBCFG_TICK_CYCLES,
  parameter int P_BUTTONS = TBCFG_NUM_BUTTONS
)
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_scan_tick,
  input wire logic [P_BUTTONS-1:0] i_touch,
  input wire logic [P_BUTTONS-1:0] o_button_active,
  input wire logic [P_BUTTONS-1:0] o_general_output_n,
  input wire logic [P_BUTTONS-1:0] o_recalibrate,
  input wire logic [P_BUTTONS-1:0] o_flank_group_member,
  input wire logic [2*P_BUTTONS-1:0] o_button_sensitivity,
  input wire logic o_auto_threshold,
  input wire logic o_noise_immunity_high
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  reset_values_a: assert property ($rose(i_rstn) |->
    o_auto_threshold && !o_noise_immunity_high && o_button_active == '0
    && o_flank_group_member == '0 && o_button_sensitivity == '0)
    else $error("config outputs wrong after reset");
  debounce_rise_a: assert property (
    (o_button_active & ~$past(o_button_active)) != '0 |-> $past(i_scan_tick)
    && (o_button_active & ~$past(o_button_active) & ~$past(i_touch)) == '0)
    else $error("button went active without a touched scan");
  touch_release_a: assert property ($past(i_scan_tick) |->
    (o_button_active & ~$past(i_touch)) == '0)
    else $error("button stayed active after an untouched scan");
  recal_pulse_a: assert property (|o_recalibrate |=>
    (o_recalibrate & $past(o_recalibrate)) == '0)
    else $error("recalibrate pulse longer than one cycle");
  recal_release_a: assert property (|o_recalibrate |=>
    (o_button_active & $past(o_recalibrate)) == '0)
    else $error("button still active after recalibrate");
  active_cause_a: assert property ($changed(o_button_active) |->
    $past(i_scan_tick) || |o_recalibrate || |$past(o_recalibrate))
    else $error("active state changed with no scan or auto reset");
  output_follow_a: assert property ($changed(o_general_output_n) |->
    $past(o_button_active) != $past(o_button_active, 2))
    else $error("button output moved without an active change");
  ack_timing_a: assert property ($changed(o_sda_oe) |->
    !i_scl && !$past(i_scl))
    else $error("data line drive changed while serial clock high");
  config_quiet_a: assert property ($changed({o_flank_group_member,
    o_button_sensitivity, o_auto_threshold, o_noise_immunity_high})
    |-> !i_scl)
    else $error("config outputs changed outside a bus write");

  cover property (|o_recalibrate);
  cover property ($rose(o_sda_oe));
  cover property ((o_button_active & ~$past(o_button_active)) != '0);
endmodule

bind tbcfg_regs tbcfg_regs_assertions #(.P_TICK_CYCLES(P_TICK_CYCLES),
  .P_BUTTONS(P_BUTTONS)) u_chk (.i_ref_clk, .i_rstn, .i_scl, .i_sda,
  .o_sda_out, .o_sda_oe, .i_scan_tick, .i_touch, .o_button_active,
  .o_general_output_n, .o_recalibrate, .o_flank_group_member,
  .o_button_sensitivity, .o_auto_threshold, .o_noise_immunity_high);

`default_nettype wire

// ### sim/test_touch_button_config_regs.sv
// Self-checking bench for the touch button configuration register bank
`timescale 1ns/10ps
`default_nettype none

module test_touch_button_config_regs;
  import tbcfg_pkg::*;
  localparam int TICK = 2;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_scan_tick = 1'b0;
  logic [9:0] i_touch = '0;
  logic scl, host_oe, sda_out, dut_oe, auto_thr, noise, nak, ok;
  wire logic sda;
  logic [9:0] act, gpo_n, recal, flank, m_act, m_gpo, blk;
  logic [19:0] sens;
  logic [7:0] mem [16];
  logic [7:0] mask [16];
  logic [6:0] dev = 7'h37;
  int cnt [10];
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;

  // Open-drain line with pull-up
  assign sda = ~(host_oe | dut_oe);
  always #50 i_ref_clk = ~i_ref_clk;

  tbcfg_regs #(.P_TICK_CYCLES(TICK)) DUT (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(dut_oe), .i_scan_tick(i_scan_tick), .i_touch(i_touch),
    .o_button_active(act), .o_general_output_n(gpo_n),
    .o_recalibrate(recal), .o_flank_group_member(flank),
    .o_button_sensitivity(sens), .o_auto_threshold(auto_thr),
    .o_noise_immunity_high(noise));
  tbcfg_host_model host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_oe(host_oe));

  // ----------------------------------------------------------------
  // Checks and transfers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: register expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_pin(input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: port expected %h got %h", $time, e, g);
    end
  endtask

  task automatic regw(input logic [7:0] o, input logic [7:0] d);
    host.wr(dev, o, d, nak);
    chk_pin(20'h0, {19'h0, nak});
    mem[o[3:0]] = d & mask[o[3:0]];
    if (o == 8'h01)
      dev = d[6:0];
  endtask

  task automatic regr(input logic [7:0] o);
    logic [7:0] q;
    host.rd(dev, o, q, nak);
    chk_pin(20'h0, {19'h0, nak});
    chk_reg(mem[o[3:0]], q);
  endtask

  task automatic chk_cfg();
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk_pin({mem[11][3:0], mem[10], mem[9]}, sens);
    chk_pin({10'h0, mem[5][1:0], mem[4]}, {10'h0, flank});
    chk_pin({18'h0, mem[2][1:0]}, {18'h0, auto_thr, noise});
    chk_pin(20'h0, {19'h0, sda_out});
  endtask

  task automatic scan(input logic [9:0] t);
    logic [7:0] deb;
    logic tg;
    i_touch = t;
    i_scan_tick = 1'b1;
    for (int b = 0; b < 10; b++)
    begin
      deb = (b == 0) ? mem[14] : mem[15];
      tg = (b < 8) ? mem[6][b] : mem[7][b-8];
      cnt[b] = t[b] ? cnt[b] + 1 : 0;
      if (!t[b])
        blk[b] = 1'b0;
      if (t[b] && !m_act[b] && !blk[b] && cnt[b] >= deb && tg)
        m_gpo[b] = ~m_gpo[b];
      m_act[b] = t[b] && (m_act[b] || (!blk[b] && cnt[b] >= deb));
      if (!tg)
        m_gpo[b] = ~m_act[b];
    end
    @(posedge i_ref_clk);
    #1;
    i_scan_tick = 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk_pin({10'h0, m_act}, {10'h0, act});
    chk_pin({10'h0, m_gpo}, {10'h0, gpo_n});
  endtask

  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    logic [7:0] d;
    int n, ex;
    void'($urandom(75788));
    mem = '{1: 8'h37, 2: 8'h02, 14: 8'h01, 15: 8'h01, default: 8'h00};
    mask = '{1: 8'h7F, 2: 8'h0F, 4: 8'hFF, 5: 8'h03, 6: 8'hFF, 7: 8'h03,
      9: 8'hFF, 10: 8'hFF, 11: 8'h0F, 14: 8'hFF, 15: 8'hFF,
      default: 8'h00};
    m_act = '0;
    m_gpo = '1;
    blk = '0;
    cnt = '{default: 0};
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rstn = 1'b1;
    chk_cfg();
    chk_pin({10'h0, 10'h3FF}, {act, gpo_n});
    for (int o = 0; o < 16; o++) regr(o[7:0]);
    for (int o = 2; o < 16; o++)
    begin
      d = 8'($urandom);
      // Host keeps debounce counts nonzero
      if (o >= 14)
        d = d | 8'h01;
      regw(o[7:0], d);
    end
    for (int o = 0; o < 16; o++) regr(o[7:0]);
    chk_cfg();
    host.hc = 6;
    regw(8'h01, 8'h2A);
    host.wr(7'h37, 8'h04, 8'hFF, nak);
    chk_pin(20'h1, {19'h0, nak});
    host.hc = 3;
    regw(8'h01, 8'hFF);
    regr(8'h01);
    regw(8'h01, 8'h37);
    regw(8'h0E, 8'h03);
    regw(8'h0F, 8'h01);
    regw(8'h06, 8'h02);
    regw(8'h07, 8'h01);
    for (int i = 0; i < 16; i++) scan(i < 4 ? 10'h3FF : 10'($urandom));
    scan(10'h000);
    for (int c = 0; c < 4; c++)
    begin
      regw(8'h02, 8'(c << 2) | 8'h02);
      ex = (c == 2) ? 5000 * TICK : 20000 * TICK;
      scan(10'h004);
      n = 0;
      while (recal === '0 && n < ((c < 2) ? 10500 : ex + 20))
      begin
        @(posedge i_ref_clk);
        #1;
        n++;
      end
      ok = (c < 2) ? (n >= 10500) : (n >= ex - 10 && n <= ex + 10);
      chk_pin(20'h1, {19'h0, ok});
      chk_pin({10'h0, (c >= 2) ? 10'h004 : 10'h000}, {10'h0, recal});
      if (c >= 2)
      begin
        m_act[2] = 1'b0;
        m_gpo[2] = 1'b1;
        blk[2] = 1'b1;
      end
      scan(10'h004);
      scan(10'h000);
    end
    finish_test();
  end
endmodule

`default_nettype wire
